/* File: flash_host.sv */
// Host controller framing single, dual and four-lane flash commands
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
// Functional notes
// - Four-lane bytes move upper nibble first
// - All fields go most significant bit first
// - Over 256 program bytes wrap the page
// - Security register chosen by address bits 15:8
// - Security register 0 is refused
// - Dual address: odd bits lane1, even lane0
// - Quad address: one nibble per clock
// - Wrap bits on lanes 2..0, clock seven
// - Quad data: two clocks per byte
// - Word read needs even address
// - Octal word read needs 16-byte alignment
// - Write-class commands need latch set first
module flash_host
  import flash_host_pkg::*;
#(
  parameter int SCK_HALF = SCK_HALF_CYC  // Clocks per half serial clock
)
(
  // Clock and reset
  input  wire logic        REF_CLK_I,
  input  wire logic        RSTN_I,
  // Software register port
  input  wire logic [7:0]  ADDR_I,
  input  wire logic [31:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [31:0] RDATA_O,
  // Flash pins
  output logic             FLASH_CS_N_O,
  output logic             FLASH_SCK_O,
  input  wire logic [3:0]  LANE_I,
  output logic      [3:0]  LANE_O,
  output logic      [3:0]  LANE_OE_O
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  state_t                state_q;        // Engine state
  phase_t                phase_q;        // Field being shifted
  logic [CMD_BITS-1:0]   cmd_q;          // Latched command word
  logic [23:0]           addr_q;         // Flash address
  logic [7:0]            modeb_q;        // Continuous mode bits / wrap bits
  logic [7:0]            param_q;        // Shadow of read_parameter_byte
  logic                  qe_q;           // Software says quad_enable_bit is set
  logic                  qpi_q;          // four_lane_command_mode shadow
  logic                  wel_q;          // write_enable_latch shadow
  logic                  wrap_q;         // Page pointer wrapped
  logic                  refused_q;      // Last command was refused
  logic [7:0]            rdbyte_q;       // Last byte taken from the flash
  logic [8:0]            page_cnt_q;     // Program bytes sent in this frame
  logic [1:0]            adr_idx_q;      // Address byte index
  logic [3:0]            steps_q;        // Clocks done in this byte/dummy
  logic [7:0]            div_q;          // Serial clock divider
  logic [3:0]            lane_s1_q;      // Pin synchroniser, first stage
  logic [3:0]            lane_s2_q;      // Pin synchroniser, second stage
  logic                  cs_n_q;
  logic                  sck_q;
  logic [3:0]            lane_q;
  logic [3:0]            oe_q;
  logic [31:0]           rdata_q;

  // ****************************************************************
  // Register decode and command checks
  // ****************************************************************
  wire        wr_cmd  = WR_I && (ADDR_I == REG_CMD);
  wire        wr_data = WR_I && (ADDR_I == REG_DATA);
  wire        wr_end  = WR_I && (ADDR_I == REG_END);
  wire [7:0]  new_op  = WDATA_I[7:0];
  wire [7:0]  op      = cmd_q[7:0];
  wire        cmd_adr = cmd_q[CMD_ADR_BIT];
  wire        cmd_mod = cmd_q[CMD_MOD_BIT];
  wire        cmd_out = cmd_q[CMD_DOUT_BIT];
  wire [1:0]  cmd_wid = cmd_q[CMD_WID_LSB +: 2];

  // Security register must be 10h, 20h or 30h with top byte zero
  wire        sec_op  = (new_op == OP_SECER) || (new_op == OP_SECPG) || (new_op == OP_SECRD);
  wire        sec_bad = (addr_q[23:16] != 8'h00) || (addr_q[11:8] != 4'h0) ||
                        (addr_q[15:8] > SEC_LAST) || (addr_q[15:8] == 8'h00);
  wire        refuse  = (needs_wel(new_op) && !wel_q) ||
                        ((new_op == OP_WORDR) && addr_q[0]) ||
                        ((new_op == OP_OCTR) && (addr_q[3:0] != 4'h0)) ||
                        (sec_op && sec_bad) ||
                        ((new_op == OP_QON) && (!qe_q || qpi_q));
  wire        accept  = wr_cmd && (state_q == ST_IDLE) && !refuse;

  // ****************************************************************
  // Timing of one serial clock
  // ****************************************************************
  wire [7:0]  last_div = 8'((2 * SCK_HALF) - 1);
  wire        step_end = ((state_q == ST_BYTE) || (state_q == ST_DUMMY)) && (div_q == last_div);
  // Opcode goes on one lane unless the flash already frames on four
  wire [1:0]  cur_w    = qpi_q ? W_QUAD : ((phase_q == PH_OPC) ? W_SINGLE : cmd_wid);
  wire        byte_end = (state_q == ST_BYTE) && step_end &&
                         (steps_q == (lane_steps(cur_w) - 4'h1));
  // Dummy count from the parameter shadow or from the command word
  wire [3:0]  dummy_n  = cmd_q[CMD_PDUM_BIT] ? param_q[7:4] : cmd_q[CMD_DUM_LSB +: 4];
  wire        dum_end  = (state_q == ST_DUMMY) && step_end && (steps_q == (dummy_n - 4'h1));

  // ****************************************************************
  // Field sequencing after each byte
  // ****************************************************************
  // Order: opcode, three address bytes, mode byte, dummy clocks, data
  wire        more_adr = ((phase_q == PH_OPC) && cmd_adr) ||
                         ((phase_q == PH_ADR) && (adr_idx_q != 2'd2));
  wire        more_mod = !more_adr && cmd_mod && ((phase_q == PH_OPC) || (phase_q == PH_ADR));
  wire        more_dum = !more_adr && !more_mod && (dummy_n != 4'h0) &&
                         (phase_q != PH_DAT) && (phase_q != PH_MOD || 1'b1);
  wire [1:0]  nxt_idx  = (phase_q == PH_OPC) ? 2'd0 : 2'(adr_idx_q + 2'd1);
  wire [7:0]  adr_byte = (nxt_idx == 2'd0) ? addr_q[23:16] :
                         (nxt_idx == 2'd1) ? addr_q[15:8] : addr_q[7:0];
  // Wrap setting only keeps bits 6..4, the rest of that input is zero
  wire [7:0]  mod_byte = (op == OP_WRAPS) ? {1'b0, modeb_q[6:4], 4'h0} : modeb_q;
  wire        prog_op  = (op == OP_PP) || (op == OP_QPP) || (op == OP_SECPG);

  // Shifter load: opcode on accept, header bytes in sequence, data on demand
  wire        ld_hdr   = byte_end && (more_adr || more_mod);
  wire        ld_dat   = wr_data && (state_q == ST_WAIT);
  wire        sh_load  = accept || ld_hdr || ld_dat;
  wire [7:0]  sh_byte  = accept ? new_op :
                         ld_hdr ? (more_adr ? adr_byte : mod_byte) :
                         (cmd_out ? WDATA_I[7:0] : 8'h00);
  wire [3:0]  sh_lanes;
  wire [7:0]  sh_word;

  lane_shifter u_shift (
    .clk_i   (REF_CLK_I),
    .rstn_i  (RSTN_I),
    .load_i  (sh_load),
    .byte_i  (sh_byte),
    .shift_i (step_end && (state_q == ST_BYTE)),
    .width_i (cur_w),
    .lanes_i (lane_s2_q),
    .lanes_o (sh_lanes),
    .byte_o  (sh_word)
  );

  // Captured byte completes with the last shift, so rebuild it here from
  // the register and the lanes sampled at that same edge
  wire [7:0]  rx_byte  = (cur_w == W_QUAD) ? {sh_word[3:0], lane_s2_q} :
                         (cur_w == W_DUAL) ? {sh_word[5:0], lane_s2_q[1:0]} :
                                             {sh_word[6:0], lane_s2_q[1]};

  // ****************************************************************
  // Pin drive
  // ****************************************************************
  // Host drives lanes only while it owns the field; lanes 2/3 idle high
  // in narrow modes so hold and write-protect stay inactive
  wire        drive    = (state_q == ST_BYTE) && ((phase_q != PH_DAT) || cmd_out);
  wire        narrow   = (cur_w != W_QUAD);
  wire [3:0]  oe_d     = drive ? (narrow ? ((cur_w == W_DUAL) ? 4'hF : 4'hD) : 4'hF) :
                         (narrow ? 4'hC : 4'h0);
  wire [3:0]  lane_d   = narrow ? (4'hC | sh_lanes) : sh_lanes;

  // ****************************************************************
  // Synchroniser for the lane inputs
  // ****************************************************************
  always_ff @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      lane_s1_q <= 4'h0;
      lane_s2_q <= 4'h0;
    end
    else
    begin
      lane_s1_q <= LANE_I;
      lane_s2_q <= lane_s1_q;
    end
  end

  // ****************************************************************
  // Engine state, divider and counters
  // ****************************************************************
  always_ff @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      state_q   <= ST_IDLE;
      phase_q   <= PH_OPC;
      adr_idx_q <= 2'd0;
      steps_q   <= 4'h0;
      div_q     <= 8'h00;
    end
    else
    begin
      // Divider runs only while clocks are being issued
      div_q <= (step_end || !((state_q == ST_BYTE) || (state_q == ST_DUMMY))) ?
               8'h00 : 8'(div_q + 8'h01);
      if (step_end)
        steps_q <= (byte_end || dum_end) ? 4'h0 : 4'(steps_q + 4'h1);
      unique case (state_q)
        ST_IDLE:
          if (accept)
          begin
            state_q <= ST_BYTE;
            phase_q <= PH_OPC;
          end
        ST_BYTE:
          if (byte_end)
          begin
            // Commands such as 75h, 7Ah, 50h, 06h end right after opcode
            if (more_adr)
            begin
              phase_q   <= PH_ADR;
              adr_idx_q <= nxt_idx;
            end
            else if (more_mod)
              phase_q <= PH_MOD;
            else if (more_dum)
              state_q <= ST_DUMMY;
            else
              state_q <= ST_WAIT;
          end
        ST_DUMMY:
          if (dum_end)
            state_q <= ST_WAIT;
        ST_WAIT:
          // Reads of status or ID just keep clocking; the flash repeats
          if (ld_dat)
          begin
            state_q <= ST_BYTE;
            phase_q <= PH_DAT;
          end
          else if (wr_end)
            state_q <= ST_CLOSE;
        ST_CLOSE:
          state_q <= ST_IDLE;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Software registers
  // ****************************************************************
  always_ff @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      cmd_q   <= '0;
      addr_q  <= 24'h000000;
      modeb_q <= 8'h00;
      qe_q    <= 1'b0;
    end
    else
    begin
      if (accept)
        cmd_q <= WDATA_I[CMD_BITS-1:0];
      if (WR_I && (ADDR_I == REG_ADDR) && (state_q == ST_IDLE))
        addr_q <= WDATA_I[23:0];
      if (WR_I && (ADDR_I == REG_MODE) && (state_q == ST_IDLE))
        modeb_q <= WDATA_I[7:0];
      if (WR_I && (ADDR_I == REG_CTRL))
        qe_q <= WDATA_I[0];
    end
  end

  // ****************************************************************
  // Shadows of the flash state kept by the host
  // ****************************************************************
  wire        opc_done = byte_end && (phase_q == PH_OPC);
  wire        dat_done = byte_end && (phase_q == PH_DAT);

  always_ff @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      qpi_q      <= 1'b0;
      wel_q      <= 1'b0;
      param_q    <= PARAM_RST;
      wrap_q     <= 1'b0;
      refused_q  <= 1'b0;
      page_cnt_q <= 9'h000;
    end
    else
    begin
      if (wr_cmd && (state_q == ST_IDLE))
        refused_q <= refuse;
      if (accept)
      begin
        wrap_q     <= 1'b0;
        page_cnt_q <= 9'h000;
      end
      if (opc_done && (op == OP_QON) && !qpi_q)
        qpi_q <= 1'b1;
      if (opc_done && (op == OP_QOFF) && qpi_q)
        qpi_q <= 1'b0;
      if (opc_done && (op == OP_WREN))
        wel_q <= 1'b1;
      if (opc_done && (op == OP_WRDI))
        wel_q <= 1'b0;
      if ((state_q == ST_CLOSE) && (needs_wel(op) || (op == OP_RST)))
        wel_q <= 1'b0;
      // Shadow takes the parameter byte as software hands it over
      if (ld_dat && cmd_out && (op == OP_SETPR))
        param_q <= WDATA_I[7:0];
      if (dat_done && cmd_out && prog_op)
      begin
        page_cnt_q <= (page_cnt_q == PAGE_BYTES) ? PAGE_BYTES : 9'(page_cnt_q + 9'h001);
        if (page_cnt_q == PAGE_BYTES)
          wrap_q <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Received byte and read port
  // ****************************************************************
  always_ff @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      rdbyte_q <= 8'h00;
      rdata_q  <= 32'h00000000;
    end
    else
    begin
      if (dat_done && !cmd_out)
        rdbyte_q <= rx_byte;
      if (RD_I)
        unique case (ADDR_I)
          REG_CMD:  rdata_q <= {14'h0000, cmd_q};
          REG_ADDR: rdata_q <= {8'h00, addr_q};
          REG_MODE: rdata_q <= {24'h000000, modeb_q};
          REG_DATA: rdata_q <= {24'h000000, rdbyte_q};
          REG_STAT: rdata_q <= {23'h000000, page_cnt_q == PAGE_BYTES, 2'b00, wrap_q,
                                refused_q, wel_q, qpi_q, state_q != ST_IDLE,
                                (state_q != ST_IDLE) && (state_q != ST_WAIT)};
          REG_CTRL: rdata_q <= {16'h0000, param_q, 7'h00, qe_q};
          default:  rdata_q <= 32'h00000000;
        endcase
      else
        rdata_q <= 32'h00000000;
    end
  end

  // ****************************************************************
  // Registered pin outputs
  // ****************************************************************
  // Lanes change while the serial clock is low; flash samples on its rise
  always_ff @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      cs_n_q <= 1'b1;
      sck_q  <= 1'b0;
      lane_q <= 4'hC;
      oe_q   <= 4'hC;
    end
    else
    begin
      cs_n_q <= accept ? 1'b0 : ((state_q == ST_CLOSE) ? 1'b1 : cs_n_q);
      sck_q  <= ((state_q == ST_BYTE) || (state_q == ST_DUMMY)) &&
                (div_q >= 8'(SCK_HALF)) && !step_end;
      lane_q <= lane_d;
      oe_q   <= oe_d;
    end
  end

  assign FLASH_CS_N_O = cs_n_q;
  assign FLASH_SCK_O  = sck_q;
  assign LANE_O       = lane_q;
  assign LANE_OE_O    = oe_q;
  assign RDATA_O      = rdata_q;

endmodule

/* File: flash_host_checker.sv */
// Pin and register-port assertions for the flash host
`timescale 1ns/1ps
module flash_host_checker #(parameter int SCK_HALF = 4) (
  input wire logic REF_CLK_I, RSTN_I, WR_I, RD_I, FLASH_CS_N_O, FLASH_SCK_O,
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WDATA_I, RDATA_O,
  input wire logic [3:0] LANE_I, LANE_O, LANE_OE_O
);
  // ***
  // Helpers
  // ***
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RSTN_I);
  logic [7:0] hi_q, gap_q;  // High run length, cycles since last rise
  logic sck_q;              // Clock one cycle ago
  always_ff @(posedge REF_CLK_I or negedge RSTN_I)
    if (!RSTN_I)
    begin
      hi_q <= 8'h00;
      gap_q <= 8'h00;
      sck_q <= 1'b0;
    end
    else
    begin
      sck_q <= FLASH_SCK_O;
      hi_q <= FLASH_SCK_O ? hi_q + 8'h01 : 8'h00;
      // Gap stays 0 until the first rise of a frame, so that rise is not judged
      gap_q <= FLASH_CS_N_O ? 8'h00 : (FLASH_SCK_O && !sck_q) ? 8'h01 :
               (gap_q == 8'hFF || gap_q == 8'h00) ? gap_q : gap_q + 8'h01;
    end
  a_sck_idle_low: assert property (FLASH_CS_N_O |-> !FLASH_SCK_O) else $error("clk off select");
  a_cs_fall_quiet: assert property ($fell(FLASH_CS_N_O) |-> !FLASH_SCK_O) else $error("cs fall");
  a_cs_rise_quiet: assert property ($rose(FLASH_CS_N_O) |-> $past(FLASH_SCK_O) == 1'b0)
    else $error("cs rise");
  a_lanes_hold: assert property (FLASH_SCK_O |-> $stable(LANE_O)) else $error("lane moved");
  a_oe_hold: assert property (FLASH_SCK_O |-> $stable(LANE_OE_O)) else $error("oe moved");
  a_sck_high_len: assert property ($fell(FLASH_SCK_O) |-> hi_q == SCK_HALF - 1)
    else $error("high time");
  a_sck_period: assert property (FLASH_SCK_O && !sck_q && gap_q != 8'h00 |-> gap_q >= 2 * SCK_HALF)
    else $error("period");
  a_rdata_idle: assert property (!$past(RD_I) |-> RDATA_O == 32'h0) else $error("rdata");
  c_frame: cover property ($fell(FLASH_CS_N_O));
  c_quad: cover property (!FLASH_CS_N_O && LANE_OE_O == 4'hF);
  c_read: cover property (RD_I ##1 RDATA_O != 32'h0);
endmodule
bind flash_host flash_host_checker #(.SCK_HALF(SCK_HALF)) i_flash_host_checker (
  .REF_CLK_I(REF_CLK_I), .RSTN_I(RSTN_I), .WR_I(WR_I), .RD_I(RD_I), .ADDR_I(ADDR_I),
  .WDATA_I(WDATA_I), .RDATA_O(RDATA_O), .FLASH_CS_N_O(FLASH_CS_N_O),
  .FLASH_SCK_O(FLASH_SCK_O), .LANE_I(LANE_I), .LANE_O(LANE_O), .LANE_OE_O(LANE_OE_O));

/* File: flash_host_pkg.sv */
// Constants, types and helpers shared by the four-lane flash host controller
package flash_host_pkg;

  // ****************************************************************
  // Software register offsets
  // ****************************************************************
  localparam logic [7:0] REG_CMD  = 8'h00;  // Opcode and framing, write starts
  localparam logic [7:0] REG_ADDR = 8'h04;  // 24-bit flash address
  localparam logic [7:0] REG_MODE = 8'h08;  // Mode byte or wrap bits
  localparam logic [7:0] REG_DATA = 8'h0C;  // Data byte out / last byte in
  localparam logic [7:0] REG_STAT = 8'h10;  // Engine and shadow status
  localparam logic [7:0] REG_END  = 8'h14;  // Any write in the wait state closes the frame
  localparam logic [7:0] REG_CTRL = 8'h18;  // Quad enable knowledge, param

  // ****************************************************************
  // Field positions of the command register
  // ****************************************************************
  localparam int CMD_WID_LSB  = 8;   // Lane width of addr/mode/data, 2 bits
  localparam int CMD_ADR_BIT  = 10;  // Send three address bytes
  localparam int CMD_MOD_BIT  = 11;  // Send the mode byte
  localparam int CMD_DUM_LSB  = 12;  // Dummy clocks, 4 bits
  localparam int CMD_PDUM_BIT = 16;  // Dummy clocks from read parameter
  localparam int CMD_DOUT_BIT = 17;  // Data phase driven by the host
  localparam int CMD_BITS     = 18;

  // ****************************************************************
  // Reset values, lane widths and counts
  // ****************************************************************
  localparam logic [7:0] PARAM_RST  = 8'h00;
  localparam logic [1:0] W_SINGLE   = 2'h0;
  localparam logic [1:0] W_DUAL     = 2'h1;
  localparam logic [1:0] W_QUAD     = 2'h2;
  localparam logic [8:0] PAGE_BYTES = 9'h100;
  localparam logic [7:0] SEC_LAST   = 8'h30;
  localparam int CLK_NS       = 8;
  localparam int SCK_HALF_NS  = 32;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;

  // ****************************************************************
  // Opcodes
  // ****************************************************************
  localparam logic [7:0] OP_WREN  = 8'h06;
  localparam logic [7:0] OP_WRDI  = 8'h04;
  localparam logic [7:0] OP_WRSR  = 8'h01;
  localparam logic [7:0] OP_PP    = 8'h02;
  localparam logic [7:0] OP_QPP   = 8'h32;
  localparam logic [7:0] OP_SE    = 8'h20;
  localparam logic [7:0] OP_BE32  = 8'h52;
  localparam logic [7:0] OP_BE64  = 8'hD8;
  localparam logic [7:0] OP_CE1   = 8'hC7;
  localparam logic [7:0] OP_CE2   = 8'h60;
  localparam logic [7:0] OP_SECER = 8'h44;
  localparam logic [7:0] OP_SECPG = 8'h42;
  localparam logic [7:0] OP_SECRD = 8'h48;
  localparam logic [7:0] OP_SETPR = 8'hC0;
  localparam logic [7:0] OP_WRAPS = 8'h77;
  localparam logic [7:0] OP_WORDR = 8'hE7;
  localparam logic [7:0] OP_OCTR  = 8'hE3;
  localparam logic [7:0] OP_QON   = 8'h38;
  localparam logic [7:0] OP_QOFF  = 8'hFF;
  localparam logic [7:0] OP_RST   = 8'h99;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_BYTE  = 3'b001,
    ST_DUMMY = 3'b010,
    ST_WAIT  = 3'b011,
    ST_CLOSE = 3'b100
  } state_t;

  typedef enum logic [1:0] {
    PH_OPC = 2'b00,
    PH_ADR = 2'b01,
    PH_MOD = 2'b10,
    PH_DAT = 2'b11
  } phase_t;

  // Clocks per byte for a lane width
  function automatic logic [3:0] lane_steps(input logic [1:0] w);
    lane_steps = (w == W_QUAD) ? 4'h2 : ((w == W_DUAL) ? 4'h4 : 4'h8);
  endfunction

  // Opcodes that need the write-enable latch and clear it on completion
  function automatic logic needs_wel(input logic [7:0] op);
    needs_wel = (op == OP_PP) || (op == OP_QPP) || (op == OP_SE) || (op == OP_BE32) ||
                (op == OP_BE64) || (op == OP_CE1) || (op == OP_CE2) || (op == OP_WRSR) ||
                (op == OP_SECER) || (op == OP_SECPG);
  endfunction

endpackage

/* File: flash_model.sv */
// Behavioural serial flash facing the host controller
`timescale 1ns/1ps
module flash_model #(parameter logic [7:0] STS = 8'h5A) (  // Status pattern is arbitrary
  input  wire logic        cs_n_i, sck_i,
  input  wire logic [3:0]  host_i, host_oe_i,
  output logic      [3:0]  lanes_o,
  output logic             wel_o, quad_o,
  output logic      [7:0]  op_o,
  output logic      [23:0] adr_o
);
  // ***
  // Framing
  // ***
  logic [11:0] n = 12'h000;  // Lane bits taken in this frame
  logic [11:0] nn;           // Count after this clock
  logic [31:0] sh, nx;       // Incoming shift register and its next value
  logic tog = 1'b0;          // Filler so a released lane never shows old data
  logic dq = 1'b0;           // Status bit being sent
  logic rdo;                 // Model drives lane1
  initial {wel_o, quad_o, op_o, adr_o} = '0;
  assign rdo = !cs_n_i && !quad_o && op_o == 8'h05 && n >= 12'h008;
  assign lanes_o = (host_oe_i & host_i) | (~host_oe_i & (rdo ? {tog, tog, dq, tog} : {4{tog}}));
  assign nn = n + (quad_o ? 12'h004 : 12'h001);
  assign nx = quad_o ? {sh[27:0], lanes_o} : {sh[30:0], lanes_o[0]};
  // Sample on rising clock; decode when select returns high
  always @(posedge sck_i or posedge cs_n_i)
    if (cs_n_i)
    begin
      n <= 12'h000;
      if (op_o == 8'h06) wel_o <= 1'b1;
      if (op_o inside {8'h04, 8'h99, 8'h01, 8'h02, 8'h32, 8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60,
          8'h42, 8'h44}) wel_o <= 1'b0;
      if (op_o == 8'h38) quad_o <= 1'b1;
      if (op_o == 8'hFF) quad_o <= 1'b0;
    end
    else
    begin
      sh <= nx;
      n <= nn;
      tog <= ~tog;
      if (nn == 12'h008) op_o <= nx[7:0];
      if (nn == 12'h020) adr_o <= nx[23:0];
    end
  // Status byte repeats for as long as the clock runs
  always @(negedge sck_i)
    dq <= STS[~n[2:0]];
endmodule

/* File: lane_shifter.sv */
// Byte shift register that spreads a byte over one, two or four lanes
`timescale 1ns/1ps
module lane_shifter
  import flash_host_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  // Control
  input  wire logic       load_i,
  input  wire logic [7:0] byte_i,
  input  wire logic       shift_i,
  input  wire logic [1:0] width_i,
  // Lanes
  input  wire logic [3:0] lanes_i,
  output logic      [3:0] lanes_o,
  output logic      [7:0] byte_o
);

  logic [7:0] sr_q;  // Upper bits leave first, input enters at the bottom
  logic [7:0] sr_d;

  // ****************************************************************
  // Shift step: most significant bits leave first
  // ****************************************************************
  // Single lane takes input on lane1, dual on lane1/lane0 odd/even
  assign sr_d = (width_i == W_QUAD) ? {sr_q[3:0], lanes_i} :
                (width_i == W_DUAL) ? {sr_q[5:0], lanes_i[1:0]} :
                                      {sr_q[6:0], lanes_i[1]};

  // Quad puts bit 7 on lane3, dual odd bit on lane1, single on lane0
  assign lanes_o = (width_i == W_QUAD) ? sr_q[7:4] :
                   (width_i == W_DUAL) ? {2'b00, sr_q[7:6]} :
                                         {3'b000, sr_q[7]};
  assign byte_o  = sr_q;

  // Load wins over shift so a new byte is never half shifted
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      sr_q <= 8'h00;
    else if (load_i)
      sr_q <= byte_i;
    else if (shift_i)
      sr_q <= sr_d;
  end

endmodule

/* File: tb.sv */
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
module tb;
  import flash_host_pkg::*;
  // ***
  // Signals and instances
  // ***
  logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00, op;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic cs_n, sck, write_enable_latch, quad;
  logic [3:0] lo, loe, li;
  logic [23:0] fa;
  logic [31:0] rf_a [6] = '{32'h0, 32'h1, 32'h8, 32'h0, 32'h11000, 32'h0};
  logic [31:0] rf_c [6] = '{32'h420, 32'h6E7, 32'h6E3, 32'h444, 32'h444, 32'h38};
  int error_cnt = 0, total_checks = 0, cyc = 0, i;
  always #4 clk = ~clk;
  flash_host #(.SCK_HALF(4)) i_flash_host (.REF_CLK_I(clk), .RSTN_I(rstn), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .FLASH_CS_N_O(cs_n),
    .FLASH_SCK_O(sck), .LANE_I(li), .LANE_O(lo), .LANE_OE_O(loe));
  flash_model i_flash_model (.cs_n_i(cs_n), .sck_i(sck), .host_i(lo), .host_oe_i(loe),
    .lanes_o(li), .wel_o(write_enable_latch), .quad_o(quad), .op_o(op), .adr_o(fa));
  task stop_test;
    $display("errors %0d checks %0d", error_cnt, total_checks);
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Poll status until the masked bits clear, bounded
  task wait_clr(input logic [31:0] m);
    v = m;
    for (int k = 0; k < 400 && (v & m) != 32'h0; k++)
      rd_reg(REG_STAT, v);
    chk(v & m, 32'h0);
  endtask
  task go(input logic [31:0] c);
    wr_reg(REG_CMD, c);
    wait_clr(32'h1);
    wr_reg(REG_END, 32'h0);
    wait_clr(32'h2);
  endtask
  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      error_cnt++;
      stop_test;
    end
  end
  initial
  begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    rd_reg(REG_STAT, v);
    chk(v, 32'h0);
    rd_reg(REG_CTRL, v);
    chk(v, {16'h0, PARAM_RST, 8'h00});
    // Illegal requests must not open a frame
    for (i = 0; i < 6; i++)
    begin
      wr_reg(REG_ADDR, rf_a[i]);
      wr_reg(REG_CMD, rf_c[i]);
      rd_reg(REG_STAT, v);
      chk({v[4], cs_n}, 2'b11);
      if (i == 0) go(OP_WREN);
    end
    chk(write_enable_latch, 1'b1);
    wr_reg(REG_ADDR, 32'h1000);
    go(32'h444);
    chk({op, fa}, 32'h44001000);
    chk(write_enable_latch, 1'b0);
    wr_reg(REG_CMD, 32'h05);
    wait_clr(32'h1);
    repeat (2)
    begin
      wr_reg(REG_DATA, 32'h0);
      wait_clr(32'h1);
      rd_reg(REG_DATA, v);
      chk(v[7:0], 8'h5A);
    end
    wr_reg(REG_END, 32'h0);
    wait_clr(32'h2);
    go(OP_WREN);
    wr_reg(REG_CMD, 32'h20402);
    wait_clr(32'h1);
    for (i = 0; i < 257; i++)
    begin
      wr_reg(REG_DATA, i);
      wait_clr(32'h1);
    end
    rd_reg(REG_STAT, v);
    chk(v[5], 1'b1);
    wr_reg(REG_END, 32'h0);
    wait_clr(32'h2);
    chk(write_enable_latch, 1'b0);
    wr_reg(REG_CTRL, 32'h1);
    go(OP_QON);
    chk(quad, 1'b1);
    go(OP_WREN);
    chk(write_enable_latch, 1'b1);
    go(OP_WRDI);
    chk(write_enable_latch, 1'b0);
    go(OP_WREN);
    wr_reg(REG_ADDR, 32'h123456);
    go(32'h420);
    chk({op, fa}, 32'h20123456);
    // Read parameter: four dummy clocks, wrap code 3
    wr_reg(REG_CMD, 32'h200C0);
    wait_clr(32'h1);
    wr_reg(REG_DATA, 32'h43);
    wait_clr(32'h1);
    wr_reg(REG_END, 32'h0);
    wait_clr(32'h2);
    rd_reg(REG_CTRL, v);
    chk(v[15:8], 8'h43);
    // Quad fast read with mode byte, then wrapped read, dummies from parameter
    for (i = 0; i < 2; i++)
    begin
      wr_reg(REG_CMD, i ? 32'h1040C : 32'h10CEB);
      wait_clr(32'h1);
      chk(i_flash_model.n, i ? 32'h30 : 32'h38);
      wr_reg(REG_END, 32'h0);
      wait_clr(32'h2);
      chk(op, i ? 8'h0C : 8'hEB);
    end
    go(OP_QOFF);
    chk(quad, 1'b0);
    go(OP_WREN);
    chk(write_enable_latch, 1'b1);
    stop_test;
  end
endmodule
